// File: fbwp_consts.vh
// Constants for the flash block write-protect unit
`ifndef FBWP_CONSTS_VH
`define FBWP_CONSTS_VH

// APB register byte offsets
`define FBWP_OFS_STATUS 8'h00
`define FBWP_OFS_CMD 8'h04
`define FBWP_OFS_RESULT 8'h08
`define FBWP_OFS_CONFIG 8'h0c

// Status register bit positions
`define FBWP_SR_LOCK 7
`define FBWP_SR_QE 6
`define FBWP_SR_BP_HI 5
`define FBWP_SR_BP_LO 2
`define FBWP_SR_WEL 1
`define FBWP_SR_BUSY 0

// Non-volatile status bits as delivered
`define FBWP_NV_RESET 6'h00

// Command register fields
`define FBWP_CMD_OP_HI 2
`define FBWP_CMD_OP_LO 0
`define FBWP_CMD_DAT_HI 15
`define FBWP_CMD_DAT_LO 8
`define FBWP_CMD_BLK_LO 16

// Command opcodes
`define FBWP_OP_NONE 3'h0
`define FBWP_OP_WRITE_ENABLE_CMD 3'h1
`define FBWP_OP_WRDI 3'h2
`define FBWP_OP_WRSTAT 3'h3
`define FBWP_OP_PROG 3'h4
`define FBWP_OP_BERASE 3'h5
`define FBWP_OP_CERASE 3'h6

// Result register bit positions
`define FBWP_RS_OK 0
`define FBWP_RS_NO_WEL 1
`define FBWP_RS_PROT 2
`define FBWP_RS_LOCKED 3
`define FBWP_RS_BUSY 4

// Config register bit positions
`define FBWP_CF_TBS 0

// Array operation length in clock cycles
`define FBWP_OP_CYCLES 16'h0010

`endif

// File: fbwp_nvreg.v
// Storage for the non-volatile status bits
`timescale 1ns/1ps
module fbwp_nvreg #(
	parameter W = 6
) (
	input wire clk,
	input wire rst_n,
	input wire wr_en,
	input wire [W-1:0] wr_data,
	output reg [W-1:0] rd_data
);
`include "fbwp_consts.vh"

	// Reset stands in for the factory-cleared state; cells change only on wr_en
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= `FBWP_NV_RESET;
		end else if (wr_en) begin
			rd_data <= wr_data;
		end
	end
endmodule // fbwp_nvreg

// File: fbwp_top.v
// Block write-protect unit of a serial flash, with APB register access
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
// Macros are needed by the parameter defaults, so they come in first
`include "fbwp_consts.vh"
// How it works
// - Protected target blocks program or erase inhibited
// - Select bit 0 top range, 1 bottom
// - Whole-array erase only when protect code zero
// - Lock clear: status write always allowed
// - Lock set, pin low: status write ignored
// - Lock set, pin high: status write allowed
// - Quad off: pins give protect and hold
// - Quad on: pins are data lines
// - Protection granularity is one 64 KB block
// - 256 blocks: code n protects 2^(n-1)
// - 128 blocks: top code bit means all
// - 64 blocks: code 7 and up all
// - Protect bits non-volatile, zero as delivered
module fbwp_top #(
	parameter BLK_W = 8,
	parameter OP_CYCLES = `FBWP_OP_CYCLES
) (
	input wire CLK_SYS,
	input wire RST_N,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [7:0] PADDR,
	input wire [31:0] PWDATA,
	output reg [31:0] PRDATA,
	output wire PREADY,
	output wire PSLVERR,
	input wire DATA_LINE_TWO_I,
	output reg DATA_LINE_TWO_O,
	output wire DATA_LINE_TWO_OE_N,
	input wire DATA_LINE_THREE_I,
	output reg DATA_LINE_THREE_O,
	output wire DATA_LINE_THREE_OE_N,
	input wire [1:0] QUAD_TX_DATA,
	input wire QUAD_TX_EN,
	output reg [1:0] QUAD_RX_DATA,
	output reg HOLD_ACTIVE,
	output reg ARR_START,
	output reg ARR_ERASE,
	output reg ARR_CHIP,
	output reg [BLK_W-1:0] ARR_BLOCK,
	output wire BUSY
);

	// True when blk falls in the range chosen by code and tbs.
	// A count of 2^(code-1) blocks reaches the whole array once
	// code-1 equals the address width, which gives the all-blocks
	// rows for the 256, 128 and 64 block arrays from one formula.
	function prot_hit;
		input [3:0] code;
		input top_bottom_select;
		input [BLK_W-1:0] blk;
		reg [BLK_W-1:0] pos;
		reg [3:0] sh;
		begin
			pos = top_bottom_select ? blk : ~blk;
			sh = code - 4'h1;
			if (code == 4'h0) begin
				prot_hit = 1'b0;
			end else if ({28'h0, sh} >= BLK_W) begin
				prot_hit = 1'b1;
			end else begin
				prot_hit = ((pos >> sh) == {BLK_W{1'b0}});
			end
		end
	endfunction

	wire [5:0] nv_bits;
	wire status_lock;
	wire quad_enable;
	wire [3:0] blk_prot;
	reg write_enable_latch_r;
	reg top_bottom_select_r;
	reg busy_r;
	reg [15:0] op_cnt_r;
	reg [4:0] result_r;
	reg [31:0] cmd_last_r;
	reg nv_wr;
	reg [5:0] nv_wdata;

	// Field split of the stored status bits
	assign status_lock = nv_bits[5];
	assign quad_enable = nv_bits[4];
	assign blk_prot = nv_bits[3:0];

	// Non-volatile lock, quad and protect cells
	fbwp_nvreg #(
		.W(6)
	) u_nv (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.wr_en(nv_wr),
		.wr_data(nv_wdata),
		.rd_data(nv_bits)
	);

	// Shared pins: with quad off they are inputs only
	wire wp_level;
	assign wp_level = quad_enable ? 1'b1 : DATA_LINE_TWO_I;
	assign DATA_LINE_TWO_OE_N = ~(quad_enable & QUAD_TX_EN);
	assign DATA_LINE_THREE_OE_N = ~(quad_enable & QUAD_TX_EN);

	// Pin data out and in, through flops
	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			DATA_LINE_TWO_O <= 1'b0;
			DATA_LINE_THREE_O <= 1'b0;
			QUAD_RX_DATA <= 2'h0;
			HOLD_ACTIVE <= 1'b0;
		end else begin
			DATA_LINE_TWO_O <= QUAD_TX_DATA[0];
			DATA_LINE_THREE_O <= QUAD_TX_DATA[1];
			QUAD_RX_DATA <= quad_enable ?
				{DATA_LINE_THREE_I, DATA_LINE_TWO_I} : 2'h0;
			// Hold is meaningless once the pin carries data
			HOLD_ACTIVE <= ~quad_enable & ~DATA_LINE_THREE_I;
		end
	end

	// APB decode
	wire apb_wr;
	wire apb_setup;
	wire addr_ok;
	assign apb_wr = PSEL & PENABLE & PWRITE;
	assign apb_setup = PSEL & ~PENABLE;
	assign addr_ok = (PADDR == `FBWP_OFS_STATUS) ||
		(PADDR == `FBWP_OFS_CMD) ||
		(PADDR == `FBWP_OFS_RESULT) ||
		(PADDR == `FBWP_OFS_CONFIG);
	// Zero wait states: every access ends in its first access cycle
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL & PENABLE & ~addr_ok;

	// Command fields from the write data
	wire cmd_wr;
	wire [2:0] cmd_op;
	wire [7:0] cmd_dat;
	wire [BLK_W-1:0] cmd_blk;
	assign cmd_wr = apb_wr && (PADDR == `FBWP_OFS_CMD);
	assign cmd_op = PWDATA[`FBWP_CMD_OP_HI:`FBWP_CMD_OP_LO];
	assign cmd_dat = PWDATA[`FBWP_CMD_DAT_HI:`FBWP_CMD_DAT_LO];
	assign cmd_blk = PWDATA[`FBWP_CMD_BLK_LO+BLK_W-1:`FBWP_CMD_BLK_LO];

	// Protection of the addressed block, straight from the live bits
	wire tgt_prot;
	wire any_prot;
	wire stat_wr_ok;
	assign tgt_prot = prot_hit(blk_prot, top_bottom_select_r,
		cmd_blk);
	assign any_prot = (blk_prot != 4'h0);
	assign stat_wr_ok = ~status_lock | wp_level;

	// Command outcome, decided in the cycle the command is written
	reg acc;
	reg [4:0] res_nxt;
	reg start_nxt;
	always @* begin
		acc = 1'b0;
		res_nxt = 5'h00;
		start_nxt = 1'b0;
		nv_wr = 1'b0;
		nv_wdata = nv_bits;
		if (busy_r) begin
			// Every command is refused with the busy result during an array operation
			res_nxt[`FBWP_RS_BUSY] = 1'b1;
		end else if (cmd_op == `FBWP_OP_WRITE_ENABLE_CMD ||
			cmd_op == `FBWP_OP_WRDI || cmd_op == `FBWP_OP_NONE) begin
			acc = 1'b1;
		end else if (!write_enable_latch_r) begin
			res_nxt[`FBWP_RS_NO_WEL] = 1'b1;
		end else if (cmd_op == `FBWP_OP_WRSTAT) begin
			if (stat_wr_ok) begin
				acc = 1'b1;
				nv_wr = cmd_wr;
				nv_wdata = cmd_dat[`FBWP_SR_LOCK:`FBWP_SR_BP_LO];
			end else begin
				res_nxt[`FBWP_RS_LOCKED] = 1'b1;
			end
		end else if (cmd_op == `FBWP_OP_CERASE) begin
			if (any_prot) begin
				res_nxt[`FBWP_RS_PROT] = 1'b1;
			end else begin
				acc = 1'b1;
				start_nxt = 1'b1;
			end
		end else if (cmd_op == `FBWP_OP_PROG ||
			cmd_op == `FBWP_OP_BERASE) begin
			if (tgt_prot) begin
				res_nxt[`FBWP_RS_PROT] = 1'b1;
			end else begin
				acc = 1'b1;
				start_nxt = 1'b1;
			end
		end
		res_nxt[`FBWP_RS_OK] = acc;
	end

	// Write enable latch, array operation timer and results
	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			write_enable_latch_r <= 1'b0;
			busy_r <= 1'b0;
			op_cnt_r <= 16'h0000;
			result_r <= 5'h00;
			cmd_last_r <= 32'h00000000;
			ARR_START <= 1'b0;
			ARR_ERASE <= 1'b0;
			ARR_CHIP <= 1'b0;
			ARR_BLOCK <= {BLK_W{1'b0}};
		end else begin
			ARR_START <= 1'b0;
			if (busy_r) begin
				// Completion clears the latch; a command written now is refused as busy
				if (op_cnt_r == 16'h0001) begin
					busy_r <= 1'b0;
					write_enable_latch_r <= 1'b0;
				end
				op_cnt_r <= op_cnt_r - 16'h0001;
			end
			if (cmd_wr) begin
				cmd_last_r <= PWDATA;
				result_r <= res_nxt;
				if (!busy_r && cmd_op == `FBWP_OP_WRITE_ENABLE_CMD) begin
					write_enable_latch_r <= 1'b1;
				end
				if (!busy_r && cmd_op == `FBWP_OP_WRDI) begin
					write_enable_latch_r <= 1'b0;
				end
				// Status write is immediate, so it drops the latch now
				if (nv_wr) begin
					write_enable_latch_r <= 1'b0;
				end
				if (start_nxt) begin
					busy_r <= 1'b1;
					// An override may be 32 bits wide; the timer keeps 16
					op_cnt_r <= OP_CYCLES[15:0];
					ARR_START <= 1'b1;
					ARR_ERASE <= (cmd_op != `FBWP_OP_PROG);
					ARR_CHIP <= (cmd_op == `FBWP_OP_CERASE);
					ARR_BLOCK <= cmd_blk;
				end
			end
		end
	end

	assign BUSY = busy_r;

	// Top/bottom select: once bottom is chosen it stays
	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			top_bottom_select_r <= 1'b0;
		end else if (apb_wr && (PADDR == `FBWP_OFS_CONFIG) &&
			PWDATA[`FBWP_CF_TBS]) begin
			top_bottom_select_r <= 1'b1;
		end
	end

	// Status register image as software reads it
	wire [7:0] status_img;
	assign status_img = {status_lock, quad_enable, blk_prot,
		write_enable_latch_r, busy_r};

	// Read data is latched in the setup cycle, valid in access
	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			PRDATA <= 32'h00000000;
		end else if (apb_setup && !PWRITE) begin
			if (PADDR == `FBWP_OFS_STATUS) begin
				PRDATA <= {24'h000000, status_img};
			end else if (PADDR == `FBWP_OFS_CMD) begin
				PRDATA <= cmd_last_r;
			end else if (PADDR == `FBWP_OFS_RESULT) begin
				PRDATA <= {27'h0000000, result_r};
			end else if (PADDR == `FBWP_OFS_CONFIG) begin
				PRDATA <= {31'h00000000, top_bottom_select_r};
			end else begin
				PRDATA <= 32'h00000000;
			end
		end
	end
endmodule // fbwp_top

// File: fbwp_chk_monitor.sv
// Assertion checker for the block write-protect unit
`timescale 1ns/1ps
module fbwp_chk #(
	parameter OP_CYCLES = 16
) (
	input wire CLK_SYS,
	input wire RST_N,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [7:0] PADDR,
	input wire PREADY,
	input wire PSLVERR,
	input wire DATA_LINE_TWO_OE_N,
	input wire DATA_LINE_THREE_I,
	input wire QUAD_TX_EN,
	input wire HOLD_ACTIVE,
	input wire ARR_START,
	input wire BUSY
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	reg [15:0] cnt_r;
	// Busy length; cleared whenever busy drops so each run counts alone
	always @(posedge CLK_SYS or negedge RST_N)
		if (!RST_N)
			cnt_r <= 16'h0000;
		else
			cnt_r <= BUSY ? cnt_r + 16'h0001 : 16'h0000;
	sequence cmd_wr;
		PSEL && PENABLE && PWRITE && PADDR == 8'h04;
	endsequence
	ready_high_a: assert property (PREADY) else $error("ready low");
	err_unmapped_a: assert property (PSEL && PENABLE && PADDR > 8'h0c
		|-> PSLVERR) else $error("no error on unmapped access");
	err_setup_a: assert property (!PENABLE |-> !PSLVERR)
		else $error("error outside access phase");
	start_cause_a: assert property (ARR_START |->
		$past(PSEL && PENABLE && PWRITE && PADDR == 8'h04))
		else $error("start without command write");
	start_pulse_a: assert property (ARR_START |-> $rose(BUSY)
		##1 !ARR_START) else $error("start not a single pulse");
	busy_len_a: assert property ($fell(BUSY) |-> cnt_r == OP_CYCLES)
		else $error("busy length wrong");
	quad_drive_a: assert property (!DATA_LINE_TWO_OE_N |-> QUAD_TX_EN)
		else $error("pin driven without request");
	hold_pin_a: assert property (HOLD_ACTIVE |->
		$past(!DATA_LINE_THREE_I)) else $error("hold without pin low");
	cover property (cmd_wr ##1 ARR_START);
endmodule // fbwp_chk

bind fbwp_top fbwp_chk #(.OP_CYCLES(OP_CYCLES)) u_chk (.CLK_SYS(CLK_SYS),
	.RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.DATA_LINE_TWO_OE_N(DATA_LINE_TWO_OE_N),
	.DATA_LINE_THREE_I(DATA_LINE_THREE_I), .QUAD_TX_EN(QUAD_TX_EN),
	.HOLD_ACTIVE(HOLD_ACTIVE), .ARR_START(ARR_START), .BUSY(BUSY));

// File: fbwp_pins.sv
// Far-side pin model resolving the two shared pins
`timescale 1ns/1ps
module fbwp_pins (
	input wire oe2_n,
	input wire o2,
	input wire oe3_n,
	input wire o3,
	input wire wp_lvl,
	input wire hold_lvl,
	output wire io2,
	output wire io3
);
	// Host lets go of a pin while the device drives it
	assign io2 = oe2_n ? wp_lvl : o2;
	assign io3 = oe3_n ? hold_lvl : o3;
endmodule // fbwp_pins

// File: test_flash_block_write_protect.sv
// Self-checking bench for the block write-protect unit
`timescale 1ns/1ps
`include "fbwp_consts.vh"
module test_flash_block_write_protect;
	reg clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	reg [7:0] padr = 8'h00;
	reg [31:0] pwd = 32'h0, q;
	reg wp = 1'b1, hold = 1'b1, txen = 1'b0, e, p;
	reg [1:0] txd = 2'h0;
	reg [2:0] op;
	wire [31:0] prd;
	wire prdy, perr, io2, io3, o2, oe2, o3, oe3, hact, st, busy;
	wire er, chp;
	wire [1:0] rxd;
	wire [7:0] blk;
	integer failures = 0, checks = 0, seed = 52031, i, c, b;
	fbwp_top #(.OP_CYCLES(4)) dut (.CLK_SYS(clk), .RST_N(rst_n),
		.PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(padr),
		.PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
		.DATA_LINE_TWO_I(io2), .DATA_LINE_TWO_O(o2),
		.DATA_LINE_TWO_OE_N(oe2), .DATA_LINE_THREE_I(io3),
		.DATA_LINE_THREE_O(o3), .DATA_LINE_THREE_OE_N(oe3),
		.QUAD_TX_DATA(txd), .QUAD_TX_EN(txen), .QUAD_RX_DATA(rxd),
		.HOLD_ACTIVE(hact), .ARR_START(st), .ARR_ERASE(er), .ARR_CHIP(chp),
		.ARR_BLOCK(blk), .BUSY(busy));
	fbwp_pins u_pins (.oe2_n(oe2), .o2(o2), .oe3_n(oe3), .o3(o3),
		.wp_lvl(wp), .hold_lvl(hold), .io2(io2), .io3(io3));
	initial forever #20 clk = ~clk;
	task report_and_stop;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		checks = checks + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer; an idle edge follows so strobes never clash
	task apb(input w, input [7:0] a, input [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (prdy !== 1'b1);
		q = prd;
		e = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task cmd(input [2:0] o, input [7:0] sd, input [7:0] bk);
		apb(1'b1, `FBWP_OFS_CMD, {8'h00, bk, sd, 5'h00, o});
		while (busy === 1'b1)
			@(posedge clk);
		apb(1'b0, `FBWP_OFS_RESULT, 32'h0);
	endtask
	task ws(input [7:0] sd);
		cmd(`FBWP_OP_WRITE_ENABLE_CMD, 8'h00, 8'h00);
		cmd(`FBWP_OP_WRSTAT, sd, 8'h00);
	endtask
	function pr(input [3:0] cd, input tb, input [7:0] bk);
		reg [8:0] n;
		begin
			n = 9'h001 << (cd - 4'h1);
			pr = cd != 0 && (cd > 8 || (tb ? bk < n : bk >= 9'h100 - n));
		end
	endfunction
	initial begin
		#200000;
		failures = failures + 1;
		report_and_stop;
	end
	// Reset values, unmapped access, refusals by latch and by busy
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, `FBWP_OFS_STATUS, 32'h0);
		chk(q, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk({q[30:0], e}, 32'h1);
		cmd(`FBWP_OP_PROG, 8'h00, 8'h00);
		chk(q, 32'h2);
		// The second write lands inside the op only while OP_CYCLES is at least 3
		cmd(`FBWP_OP_WRITE_ENABLE_CMD, 8'h00, 8'h00);
		apb(1'b1, `FBWP_OFS_CMD, {16'h0005, 13'h0000, `FBWP_OP_PROG});
		chk(busy, 32'h1);
		cmd(`FBWP_OP_WRITE_ENABLE_CMD, 8'h00, 8'h00);
		chk(q, 32'h10);
		apb(1'b0, `FBWP_OFS_STATUS, 32'h0);
		chk(q, 32'h0);
		cmd(`FBWP_OP_WRITE_ENABLE_CMD, 8'h00, 8'h00);
		cmd(`FBWP_OP_WRDI, 8'h00, 8'h00);
		cmd(`FBWP_OP_WRSTAT, 8'h3c, 8'h00);
		chk(q, 32'h2);
		apb(1'b0, `FBWP_OFS_CMD, 32'h0);
		chk(q, 32'h00003c03);
		$display("reset test done");
		for (i = 0; i < 40; i = i + 1) begin
			if (i == 20) begin
				apb(1'b1, `FBWP_OFS_CONFIG, 32'h1);
				apb(1'b0, `FBWP_OFS_CONFIG, 32'h0);
				chk(q, 32'h1);
			end
			c = $random(seed);
			b = (i % 4 == 1) ? 0 : (i % 4 == 2) ? 255 : $random(seed);
			op = c[5] ? `FBWP_OP_CERASE : c[4] ? `FBWP_OP_BERASE : 3'h4;
			ws({2'b00, c[3:0], 2'b00});
			apb(1'b0, `FBWP_OFS_STATUS, 32'h0);
			chk(q[7:0], {2'b00, c[3:0], 2'b00});
			cmd(`FBWP_OP_WRITE_ENABLE_CMD, 8'h00, 8'h00);
			cmd(op, 8'h00, b[7:0]);
			p = pr(c[3:0], i >= 20, b[7:0]);
			if (op == `FBWP_OP_CERASE)
				chk(q, c[3:0] != 0 ? 32'h4 : 32'h1);
			else
				chk(q, p ? 32'h4 : 32'h1);
			if (q === 32'h1)
				chk({chp, er, blk}, {op == 3'h6, op != 3'h4, b[7:0]});
		end
		$display("protect test done");
		wp <= 1'b0;
		ws(8'h80);
		chk(q, 32'h1);
		ws(8'h04);
		chk(q, 32'h8);
		apb(1'b0, `FBWP_OFS_STATUS, 32'h0);
		chk(q, 32'h82);
		wp <= 1'b1;
		ws(8'h00);
		chk(q, 32'h1);
		$display("lock test done");
		ws(8'h40);
		c = $random(seed);
		txen <= 1'b1;
		txd <= c[1:0];
		hold <= 1'b0;
		repeat (3) @(posedge clk);
		chk({oe2, oe3, hact, o3, o2, rxd}, {3'b000, txd, txd});
		ws(8'h00);
		repeat (2) @(posedge clk);
		chk({oe2, oe3, hact}, 32'h7);
		$display("quad test done");
		report_and_stop;
	end
endmodule // test_flash_block_write_protect
